// ==== rtl/qso_pkg.sv ====
// Constants of the quick-stop, output and capture block.
// Assumes one 20 MHz clock and a parameter port with fixed offsets.
package qso_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int POS_W = 32;
  localparam int CNT_W = 16;
  localparam int DOUT_W = 16;
  // ----------------------------------------
  // Parameter offsets
  // ----------------------------------------
  localparam logic [15:0] OFS_QS_DECEL = 16'h0624;
  localparam logic [15:0] OFS_QS_REACT = 16'h0630;
  localparam logic [15:0] OFS_DOUT = 16'h0822;
  localparam logic [15:0] OFS_QS_CUR = 16'h110a;
  localparam logic [15:0] OFS_HALT_CUR = 16'h110c;
  localparam logic [15:0] OFS_CAP_DONE = 16'h0a02;
  localparam logic [15:0] OFS_CAPTURE_INPUT_ONE_EDGE = 16'h0a04;
  localparam logic [15:0] OFS_CAPTURE_INPUT_TWO_EDGE = 16'h0a06;
  localparam logic [15:0] OFS_CAPTURE_INPUT_ONE_ACT = 16'h0a08;
  localparam logic [15:0] OFS_CAPTURE_INPUT_TWO_ACT = 16'h0a0a;
  localparam logic [15:0] OFS_CAPTURE_INPUT_ONE_POS = 16'h0a0c;
  localparam logic [15:0] OFS_CAPTURE_INPUT_TWO_POS = 16'h0a0e;
  localparam logic [15:0] OFS_CAPTURE_INPUT_ONE_CNT = 16'h0a10;
  localparam logic [15:0] OFS_CAPTURE_INPUT_TWO_CNT = 16'h0a12;
  // ----------------------------------------
  // Reset values and limits
  // ----------------------------------------
  localparam logic [31:0] DECEL_RST = 32'h0000_1770;
  localparam logic [31:0] DECEL_MIN = 32'h0000_00c8;
  localparam logic [31:0] DECEL_MAX = 32'h002d_c6c0;
  localparam logic [15:0] REACT_RST = 16'h0007;
  // ----------------------------------------
  // Reaction codes, operating states
  // ----------------------------------------
  localparam logic [15:0] REACT_TQ_FAULT = 16'hfffe;
  localparam logic [15:0] REACT_DEC_FAULT = 16'hffff;
  localparam logic [15:0] REACT_DEC_HOLD = 16'h0006;
  localparam logic [15:0] REACT_TQ_HOLD = 16'h0007;
  localparam logic [3:0] OPST_RUN = 4'h6;
  localparam logic [3:0] OPST_QS_ACTIVE = 4'h7;
  localparam logic [3:0] OPST_FAULT = 4'h9;
  localparam logic [1:0] ERR_CLASS_1 = 2'h1;
  localparam logic [1:0] ERR_CLASS_2 = 2'h2;
  // ----------------------------------------
  // Capture settings, quick-stop sequencer states
  // ----------------------------------------
  localparam logic [1:0] CAP_STOP = 2'h0;
  localparam logic [1:0] CAP_ONCE = 2'h1;
  localparam logic [1:0] CAP_CONT = 2'h2;
  localparam logic EDGE_FALL = 1'b0;
  localparam logic EDGE_RISE = 1'b1;
  typedef enum logic [1:0] {QS_IDLE, QS_BRAKE, QS_HOLD, QS_FAULT} qso_state_e;
endpackage

// ==== rtl/qso_cap_if.sv ====
// Carrier between the register side and one capture unit.
// Assumes both ends share ref_clk_in.
interface qso_cap_if;
  logic act;
  logic [1:0] mode;
  logic edge_rise;
  logic done;
  logic [31:0] pos;
  logic [15:0] count;
  modport unit(input act, input mode, input edge_rise, output done, output pos, output count);
  modport ctrl(output act, output mode, output edge_rise, input done, input pos, input count);
endinterface

// ==== rtl/qso_capture.sv ====
// One position capture unit: pin filter, edge pick, latch and counter.
// Assumes the pin is asynchronous and the position is on ref_clk_in.
module qso_capture (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic pin_in,
  input wire logic [qso_pkg::POS_W-1:0] motor_pos_in,
  qso_cap_if.unit cap
);
  import qso_pkg::*;

  logic s1_r, s2_r, s3_r, lvl_r;
  logic armed_r, cont_r;
  logic edge_ok, hit, arm;

  // ----------------------------------------
  // Pin filter
  // ----------------------------------------
  // Chain runs through reset so the held level starts at the idle pin level
  always_ff @(posedge ref_clk_in) begin
    s1_r <= pin_in;
    s2_r <= s1_r;
    s3_r <= s2_r;
    if (!rst_b_in || s2_r == s3_r) begin
      lvl_r <= s3_r; // R20
    end
  end

  // Edge counts only once the two late stages agree
  assign edge_ok = (s2_r == s3_r) && (s3_r != lvl_r) && (s3_r == cap.edge_rise); // R15 R16
  assign hit = armed_r && edge_ok;
  // Only a start clears count and flag; a cancel keeps them
  assign arm = cap.act && (cap.mode != CAP_STOP);

  // ----------------------------------------
  // Arming and latch
  // ----------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      armed_r <= 1'b0;
      cont_r <= 1'b0;
    end else if (cap.act) begin
      armed_r <= (cap.mode != CAP_STOP); // R17
      cont_r <= (cap.mode == CAP_CONT);
    end else if (hit && !cont_r) begin
      armed_r <= 1'b0; // R13
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      cap.pos <= '0;
    end else if (hit) begin
      cap.pos <= motor_pos_in; // R14 R20
    end
  end

  // Capture beats a clear landing in the same cycle
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      cap.done <= 1'b0;
      cap.count <= '0;
    end else begin
      cap.done <= hit | (cap.done & ~arm); // R18
      if (arm) begin
        cap.count <= hit ? 16'h0001 : 16'h0000; // R19
      end else if (hit) begin
        cap.count <= cap.count + 16'h0001; // R19
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_once_disarms;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (hit && !cont_r && !cap.act) |=> !armed_r;
  endproperty
  a_once_disarms: assert property (p_once_disarms) else $error("one-time capture stayed armed"); // R13

  property p_pos_latch;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    hit |=> (cap.pos == $past(motor_pos_in)) && cap.done;
  endproperty
  a_pos_latch: assert property (p_pos_latch) else $error("position not latched on edge"); // R14

  property p_count_clear;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (arm && !hit) |=> (cap.count == 16'h0000);
  endproperty
  a_count_clear: assert property (p_count_clear) else $error("count not cleared on activation"); // R19

  property p_cancel_keeps;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (cap.act && !arm && !hit) |=> $stable(cap.count);
  endproperty
  a_cancel_keeps: assert property (p_cancel_keeps) else $error("cancel cleared the count"); // R19

  c_cont_two: cover property (@(posedge ref_clk_in) disable iff (!rst_b_in) (hit && cont_r) ##[1:200] hit);
endmodule

// ==== rtl/qso_top.sv ====
// Quick-stop reaction, torque limits, direct outputs and two capture units.
// Assumes a fieldbus parameter port on ref_clk_in and status inputs from the
// drive core on the same clock; capture pins arrive asynchronously.
//
// Notes on behaviour
// R1: Quick stop starts on fieldbus command or error of class 1 or 2.
// R2: After standstill, stay in state 7 or go to state 9.
// R3: Code -2 torque ramp then fault; code -1 deceleration ramp then fault.
// R4: Code 6 deceleration ramp, code 7 torque ramp, both hold; 7 is default.
// R5: Deceleration ramp only with velocity profile; otherwise torque ramp.
// R6: Reaction code changes act at once.
// R7: Quick-stop deceleration 200..3000000, default 6000, used at next movement.
// R8: Quick-stop current in 0.01 A steps, acts at once.
// R9: Halt current in 0.01 A steps, acts at once.
// R10: Writes to outputs not freely assigned are ignored.
// R11: Write bit n drives output n+1.
// R12: Two independent capture inputs on the logic lines.
// R13: One-time capture latches only the first qualifying edge.
// R14: Continuous capture latches on every qualifying edge.
// R15: Qualifying edge is rising or falling per input.
// R16: Edge select 0 falling, 1 rising, default 0, acts at once.
// R17: Activation 0 cancels, 1 one-time, 2 continuous.
// R18: Done flags: bit 0 input one, bit 1 input two.
// R19: Event counter counts captures, cleared on activation.
// R20: Inputs synchronised first; position of detection cycle is latched.
// R21: Undefined reaction code acts as code 7.
module qso_top #(
  parameter logic [15:0] QS_CUR_RST = 16'h0064,
  parameter logic [15:0] HALT_CUR_RST = 16'h0064
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic par_wr_in,
  input wire logic par_rd_in,
  input wire logic [qso_pkg::ADDR_W-1:0] par_addr_in,
  input wire logic [qso_pkg::DATA_W-1:0] par_wdata_in,
  output logic [qso_pkg::DATA_W-1:0] par_rdata_out,
  output logic par_ack_out,
  output logic par_err_out,
  input wire logic qs_cmd_in,
  input wire logic qs_release_in,
  input wire logic fault_reset_in,
  input wire logic err_detect_in,
  input wire logic [1:0] err_class_in,
  input wire logic vel_profile_in,
  input wire logic standstill_in,
  input wire logic motion_start_in,
  input wire logic halt_in,
  input wire logic [qso_pkg::DOUT_W-1:0] output_free_in,
  input wire logic logic_line_one_in,
  input wire logic logic_line_two_in,
  input wire logic [qso_pkg::POS_W-1:0] motor_pos_in,
  output logic [3:0] op_state_out,
  output logic brake_decel_out,
  output logic brake_torque_out,
  output logic [qso_pkg::DATA_W-1:0] decel_rate_out,
  output logic [15:0] torque_limit_out,
  output logic [qso_pkg::DOUT_W-1:0] dout_out
);
  import qso_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] react_eff(input logic [15:0] c);
    if (c == REACT_TQ_FAULT || c == REACT_DEC_FAULT || c == REACT_DEC_HOLD) begin
      react_eff = c;
    end else begin
      react_eff = REACT_TQ_HOLD;
    end
  endfunction

  function automatic logic wants_decel(input logic [15:0] c);
    wants_decel = (react_eff(c) == REACT_DEC_FAULT) || (react_eff(c) == REACT_DEC_HOLD);
  endfunction

  function automatic logic ends_fault(input logic [15:0] c);
    ends_fault = (react_eff(c) == REACT_TQ_FAULT) || (react_eff(c) == REACT_DEC_FAULT);
  endfunction

  // ----------------------------------------
  // Parameter registers
  // ----------------------------------------
  logic [31:0] qs_decel_r;
  logic [15:0] qs_react_r;
  logic [15:0] qs_cur_r;
  logic [15:0] halt_cur_r;
  logic edge1_r, edge2_r;
  logic [1:0] act1_r, act2_r;
  logic wr_decel, wr_react, wr_dout, wr_qcur, wr_hcur;
  logic wr_e1, wr_e2, wr_a1, wr_a2;

  assign wr_decel = par_wr_in && (par_addr_in == OFS_QS_DECEL);
  assign wr_react = par_wr_in && (par_addr_in == OFS_QS_REACT);
  assign wr_dout = par_wr_in && (par_addr_in == OFS_DOUT);
  assign wr_qcur = par_wr_in && (par_addr_in == OFS_QS_CUR);
  assign wr_hcur = par_wr_in && (par_addr_in == OFS_HALT_CUR);
  assign wr_e1 = par_wr_in && (par_addr_in == OFS_CAPTURE_INPUT_ONE_EDGE);
  assign wr_e2 = par_wr_in && (par_addr_in == OFS_CAPTURE_INPUT_TWO_EDGE);
  assign wr_a1 = par_wr_in && (par_addr_in == OFS_CAPTURE_INPUT_ONE_ACT) && (par_wdata_in[15:0] <= {14'h0000, CAP_CONT});
  assign wr_a2 = par_wr_in && (par_addr_in == OFS_CAPTURE_INPUT_TWO_ACT) && (par_wdata_in[15:0] <= {14'h0000, CAP_CONT});

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      qs_decel_r <= DECEL_RST;
    end else if (wr_decel && par_wdata_in >= DECEL_MIN && par_wdata_in <= DECEL_MAX) begin
      qs_decel_r <= par_wdata_in; // R7
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      qs_react_r <= REACT_RST; // R4
    end else if (wr_react) begin
      qs_react_r <= par_wdata_in[15:0];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      qs_cur_r <= QS_CUR_RST;
      halt_cur_r <= HALT_CUR_RST;
    end else begin
      if (wr_qcur) begin
        qs_cur_r <= par_wdata_in[15:0];
      end
      if (wr_hcur) begin
        halt_cur_r <= par_wdata_in[15:0];
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      edge1_r <= EDGE_FALL; // R16
      edge2_r <= EDGE_FALL;
      act1_r <= CAP_STOP;
      act2_r <= CAP_STOP;
    end else begin
      if (wr_e1) begin
        edge1_r <= par_wdata_in[0];
      end
      if (wr_e2) begin
        edge2_r <= par_wdata_in[0];
      end
      if (wr_a1) begin
        act1_r <= par_wdata_in[1:0];
      end
      if (wr_a2) begin
        act2_r <= par_wdata_in[1:0];
      end
    end
  end

  // ----------------------------------------
  // Direct outputs
  // ----------------------------------------
  // Only freely assigned bits take the written value
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      dout_out <= '0;
    end else if (wr_dout) begin
      dout_out <= (par_wdata_in[15:0] & output_free_in) | (dout_out & ~output_free_in); // R10 R11
    end
  end

  // ----------------------------------------
  // Quick-stop sequencer
  // ----------------------------------------
  qso_state_e st_r;
  logic qs_trig;

  assign qs_trig = qs_cmd_in ||
    (err_detect_in && (err_class_in == ERR_CLASS_1 || err_class_in == ERR_CLASS_2)); // R1

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      st_r <= QS_IDLE;
    end else begin
      case (st_r)
        QS_IDLE: begin
          if (qs_trig) begin
            st_r <= QS_BRAKE; // R1
          end
        end
        QS_BRAKE: begin
          if (standstill_in) begin
            st_r <= ends_fault(qs_react_r) ? QS_FAULT : QS_HOLD; // R2 R3 R4 R21
          end
        end
        QS_HOLD: begin
          if (qs_release_in) begin
            st_r <= QS_IDLE;
          end
        end
        QS_FAULT: begin
          if (fault_reset_in) begin
            st_r <= QS_IDLE;
          end
        end
        default: st_r <= QS_IDLE;
      endcase
    end
  end

  // Reaction code read live, so a change mid-brake acts at once
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      brake_decel_out <= 1'b0;
      brake_torque_out <= 1'b0;
      op_state_out <= OPST_RUN;
    end else begin
      brake_decel_out <= (st_r == QS_BRAKE) && wants_decel(qs_react_r) && vel_profile_in; // R5 R6
      brake_torque_out <= (st_r == QS_BRAKE) && !(wants_decel(qs_react_r) && vel_profile_in); // R5 R6
      case (st_r)
        QS_FAULT: op_state_out <= OPST_FAULT; // R2
        QS_IDLE: op_state_out <= OPST_RUN;
        default: op_state_out <= OPST_QS_ACTIVE; // R2
      endcase
    end
  end

  // Current limits are raw 0.01 A codes passed through
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      torque_limit_out <= '0;
    end else if (st_r == QS_BRAKE) begin
      torque_limit_out <= qs_cur_r; // R8
    end else if (halt_in) begin
      torque_limit_out <= halt_cur_r; // R9
    end else begin
      torque_limit_out <= '0;
    end
  end

  // Ramp only picked up when a movement begins
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      decel_rate_out <= DECEL_RST;
    end else if (motion_start_in) begin
      decel_rate_out <= qs_decel_r; // R7
    end
  end

  // ----------------------------------------
  // Capture units
  // ----------------------------------------
  qso_cap_if capture_input_one_if ();
  qso_cap_if capture_input_two_if ();

  assign capture_input_one_if.act = wr_a1;
  assign capture_input_one_if.mode = par_wdata_in[1:0];
  assign capture_input_one_if.edge_rise = edge1_r;
  assign capture_input_two_if.act = wr_a2;
  assign capture_input_two_if.mode = par_wdata_in[1:0];
  assign capture_input_two_if.edge_rise = edge2_r;

  qso_capture u_capture_input_one ( // R12
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .pin_in(logic_line_one_in),
    .motor_pos_in(motor_pos_in),
    .cap(capture_input_one_if)
  );

  qso_capture u_capture_input_two ( // R12
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .pin_in(logic_line_two_in),
    .motor_pos_in(motor_pos_in),
    .cap(capture_input_two_if)
  );

  // ----------------------------------------
  // Read-back
  // ----------------------------------------
  logic [31:0] rd_mux;
  logic rd_hit;

  always_comb begin
    rd_hit = 1'b1;
    rd_mux = '0;
    case (par_addr_in)
      OFS_QS_DECEL: rd_mux = qs_decel_r;
      OFS_QS_REACT: rd_mux = {16'h0000, qs_react_r};
      OFS_DOUT: rd_mux = {16'h0000, dout_out};
      OFS_QS_CUR: rd_mux = {16'h0000, qs_cur_r};
      OFS_HALT_CUR: rd_mux = {16'h0000, halt_cur_r};
      OFS_CAP_DONE: rd_mux = {30'h0000_0000, capture_input_two_if.done, capture_input_one_if.done}; // R18
      OFS_CAPTURE_INPUT_ONE_EDGE: rd_mux = {31'h0000_0000, edge1_r};
      OFS_CAPTURE_INPUT_TWO_EDGE: rd_mux = {31'h0000_0000, edge2_r};
      OFS_CAPTURE_INPUT_ONE_ACT: rd_mux = {30'h0000_0000, act1_r};
      OFS_CAPTURE_INPUT_TWO_ACT: rd_mux = {30'h0000_0000, act2_r};
      OFS_CAPTURE_INPUT_ONE_POS: rd_mux = capture_input_one_if.pos;
      OFS_CAPTURE_INPUT_TWO_POS: rd_mux = capture_input_two_if.pos;
      OFS_CAPTURE_INPUT_ONE_CNT: rd_mux = {16'h0000, capture_input_one_if.count};
      OFS_CAPTURE_INPUT_TWO_CNT: rd_mux = {16'h0000, capture_input_two_if.count};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      par_rdata_out <= '0;
      par_ack_out <= 1'b0;
      par_err_out <= 1'b0;
    end else begin
      par_ack_out <= par_rd_in || par_wr_in;
      par_err_out <= (par_rd_in || par_wr_in) && !rd_hit;
      par_rdata_out <= (par_rd_in && rd_hit) ? rd_mux : '0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_trig_brake;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (st_r == QS_IDLE && qs_trig) |=> (st_r == QS_BRAKE) ##1 (op_state_out == OPST_QS_ACTIVE);
  endproperty
  a_trig_brake: assert property (p_trig_brake) else $error("quick stop not started"); // R1

  property p_end_fault;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (st_r == QS_BRAKE && standstill_in && ends_fault(qs_react_r)) |=> ##1 (op_state_out == OPST_FAULT);
  endproperty
  a_end_fault: assert property (p_end_fault) else $error("fault state not reached"); // R3

  property p_end_hold;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (st_r == QS_BRAKE && standstill_in && !ends_fault(qs_react_r)) |=> ##1 (op_state_out == OPST_QS_ACTIVE);
  endproperty
  a_end_hold: assert property (p_end_hold) else $error("quick-stop state not held"); // R4

  property p_no_decel_wo_profile;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (st_r == QS_BRAKE && !vel_profile_in) |=> (brake_torque_out && !brake_decel_out);
  endproperty
  a_no_decel_wo_profile: assert property (p_no_decel_wo_profile) else $error("decel ramp without profile"); // R5

  property p_undef_code;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (st_r == QS_BRAKE && react_eff(qs_react_r) != qs_react_r) |=> brake_torque_out;
  endproperty
  a_undef_code: assert property (p_undef_code) else $error("undefined code not torque ramp"); // R21

  property p_dout_mask;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    wr_dout |=> ((dout_out & ~$past(output_free_in)) == ($past(dout_out) & ~$past(output_free_in)));
  endproperty
  a_dout_mask: assert property (p_dout_mask) else $error("locked output changed"); // R10

  property p_decel_next_move;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    !motion_start_in |=> $stable(decel_rate_out);
  endproperty
  a_decel_next_move: assert property (p_decel_next_move) else $error("ramp changed mid-move"); // R7

  c_fault_path: cover property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (st_r == QS_BRAKE) ##[1:100] (op_state_out == OPST_FAULT));
  c_decel_brake: cover property (@(posedge ref_clk_in) disable iff (!rst_b_in) brake_decel_out);
endmodule

// ==== bench/qso_far_model.sv ====
// Far side model: capture signal sources and the motor position source.
// Assumes the bench requests pin levels; pins move off the clock phase.
module qso_far_model (
  input wire logic ref_clk_in,
  input wire logic slow_in,
  input wire logic [1:0] lvl_in,
  input wire logic [31:0] pos_req_in,
  output logic [1:0] pin_out,
  output logic [31:0] pos_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial pin_out = 2'b11;
  // Odd offset so edges never line up with the sampling clock
  always @(lvl_in) begin
    if (slow_in) repeat (3) @(posedge ref_clk_in);
    #13 pin_out = lvl_in;
  end
  assign pos_out = pos_req_in;
endmodule

// ==== bench/tb_quick_stop_output_capture.sv ====
// Self-checking bench for the quick-stop, output and capture block.
// Assumes qso_pkg, qso_top and the far side model are compiled first.
module tb_quick_stop_output_capture;
  timeunit 1ns;
  timeprecision 100ps;
  import qso_pkg::*;
  logic clk, rst_b, wr, rd, err, ack, qs, rel, frst, errd, vel, still, mstart, halt, slow, dec, flt;
  logic [15:0] addr, free, dout, tlim, dm, qc, hc;
  logic [31:0] wdata, rdata, drate, preq, pos, d, p1, p3;
  logic [1:0] ecls, lvl, pins;
  logic [3:0] opst;
  logic bdec, btq;
  logic [32:0] expq[$];
  logic [31:0] dv[4] = '{DECEL_MIN - 1, DECEL_MIN, DECEL_MAX + 1, DECEL_MAX};
  logic [31:0] de[4] = '{DECEL_RST, DECEL_MIN, DECEL_MIN, DECEL_MAX};
  logic [15:0] codes[5] = '{REACT_TQ_FAULT, REACT_DEC_FAULT, REACT_DEC_HOLD, REACT_TQ_HOLD, 16'h0005};
  int n_mismatch = 0;
  int comparisons = 0;
  int k;
  integer seed = 32'h0059;

  qso_top #(.QS_CUR_RST(16'h0123), .HALT_CUR_RST(16'h0321)) dut (
    .ref_clk_in(clk), .rst_b_in(rst_b), .par_wr_in(wr), .par_rd_in(rd),
    .par_addr_in(addr), .par_wdata_in(wdata), .par_rdata_out(rdata),
    .par_ack_out(ack), .par_err_out(err), .qs_cmd_in(qs), .qs_release_in(rel),
    .fault_reset_in(frst), .err_detect_in(errd), .err_class_in(ecls),
    .vel_profile_in(vel), .standstill_in(still), .motion_start_in(mstart),
    .halt_in(halt), .output_free_in(free), .logic_line_one_in(pins[0]),
    .logic_line_two_in(pins[1]), .motor_pos_in(pos), .op_state_out(opst),
    .brake_decel_out(bdec), .brake_torque_out(btq), .decel_rate_out(drate),
    .torque_limit_out(tlim), .dout_out(dout)
  );
  qso_far_model far (
    .ref_clk_in(clk), .slow_in(slow), .lvl_in(lvl), .pos_req_in(preq), .pin_out(pins), .pos_out(pos)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // One access; the expected answer is queued for the monitor
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] v, input logic [32:0] e);
    cyc(1);
    wr = w;
    rd = !w;
    addr = a;
    wdata = v;
    expq.push_back(e);
    cyc(1);
    wr = 0;
    rd = 0;
  endtask
  task automatic wait_st(input logic [3:0] s);
    for (int i = 0; i < 8 && opst !== s; i++) cyc(1);
    check({29'h0, opst}, {29'h0, s});
  endtask
  task automatic pin(input logic [1:0] v);
    lvl = v;
    cyc(10);
  endtask
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    clk = 0;
    forever #25 clk = !clk;
  end
  initial begin
    #1_000_000;
    n_mismatch++;
    stop_test();
  end
  // Answers arrive one cycle after the strobe; oldest note first
  initial forever begin
    @(posedge clk) #1;
    if (ack === 1'b1) check({err, rdata}, expq.pop_front());
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_b, wr, rd, qs, rel, frst, errd, vel, still, mstart, halt, slow} = 0;
    {addr, free, wdata, preq, ecls, dm} = 0;
    lvl = 2'b11;
    repeat (5) @(posedge clk);
    #2 rst_b = 1;
    acc(0, OFS_QS_REACT, 0, {17'h0, REACT_RST});
    acc(0, OFS_QS_DECEL, 0, {1'b0, DECEL_RST});
    acc(0, OFS_CAPTURE_INPUT_ONE_EDGE, 0, 0);
    acc(0, 16'h0a14, 0, 33'h1_0000_0000);
    check({17'h0, dout}, 0);
    foreach (dv[i]) begin
      acc(1, OFS_QS_DECEL, dv[i], 0);
      acc(0, OFS_QS_DECEL, 0, {1'b0, de[i]});
    end
    check({1'b0, drate}, {1'b0, DECEL_RST});
    mstart = 1;
    cyc(1);
    mstart = 0;
    cyc(2);
    check({1'b0, drate}, {1'b0, DECEL_MAX});
    // Outputs only move where freely assigned
    for (int i = 0; i < 8; i++) begin
      free = (i == 0) ? 16'h0001 : 16'($random(seed));
      d = (i == 0) ? 32'h0000_0003 : $random(seed);
      dm = (dm & ~free) | (d[15:0] & free);
      acc(1, OFS_DOUT, d, 0);
      check({17'h0, dout}, {17'h0, dm});
    end
    qc = 16'($random(seed));
    hc = 16'($random(seed));
    acc(1, OFS_QS_CUR, {16'h0, qc}, 0);
    acc(1, OFS_HALT_CUR, {16'h0, hc}, 0);
    acc(0, OFS_QS_CUR, 0, {17'h0, qc});
    halt = 1;
    cyc(3);
    check({17'h0, tlim}, {17'h0, hc});
    halt = 0;
    // Class 0 and 3 errors must not stop the motor
    errd = 1;
    cyc(1);
    ecls = 2'h3;
    cyc(1);
    errd = 0;
    cyc(3);
    check({29'h0, opst}, {29'h0, OPST_RUN});
    foreach (codes[i]) for (int v = 0; v < 2; v++) begin
      acc(1, OFS_QS_REACT, {16'h0, codes[i]}, 0);
      vel = v[0];
      dec = vel && (codes[i] == REACT_DEC_FAULT || codes[i] == REACT_DEC_HOLD);
      flt = codes[i] == REACT_TQ_FAULT || codes[i] == REACT_DEC_FAULT;
      k = (i * 2 + v) % 3;
      qs = k == 0;
      errd = k != 0;
      ecls = k[1:0];
      cyc(1);
      qs = 0;
      errd = 0;
      wait_st(OPST_QS_ACTIVE);
      check({31'h0, bdec, btq}, {31'h0, dec, !dec});
      check({17'h0, tlim}, {17'h0, qc});
      still = 1;
      cyc(4);
      check({29'h0, opst}, {29'h0, flt ? OPST_FAULT : OPST_QS_ACTIVE});
      check({31'h0, bdec, btq}, 0);
      still = 0;
      rel = !flt;
      frst = flt;
      cyc(1);
      rel = 0;
      frst = 0;
      wait_st(OPST_RUN);
    end
    // Code change while braking switches the ramp at once
    acc(1, OFS_QS_REACT, {16'h0, REACT_DEC_HOLD}, 0);
    qs = 1;
    cyc(1);
    qs = 0;
    wait_st(OPST_QS_ACTIVE);
    check({31'h0, bdec, btq}, 33'h2);
    acc(1, OFS_QS_REACT, {16'h0, REACT_TQ_FAULT}, 0);
    cyc(1);
    check({31'h0, bdec, btq}, 33'h1);
    still = 1;
    cyc(4);
    check({29'h0, opst}, {29'h0, OPST_FAULT});
    still = 0;
    frst = 1;
    cyc(1);
    frst = 0;
    wait_st(OPST_RUN);
    // Unit one once on falling, unit two continuous on rising
    p1 = $random(seed);
    preq = p1;
    acc(1, OFS_CAPTURE_INPUT_ONE_ACT, 1, 0);
    acc(1, OFS_CAPTURE_INPUT_TWO_EDGE, 1, 0);
    acc(1, OFS_CAPTURE_INPUT_TWO_ACT, 2, 0);
    pin(2'b10);
    preq = $random(seed);
    pin(2'b00);
    pin(2'b11);
    p3 = $random(seed);
    preq = p3;
    slow = 1;
    pin(2'b00);
    pin(2'b10);
    slow = 0;
    acc(0, OFS_CAPTURE_INPUT_ONE_POS, 0, {1'b0, p1});
    acc(0, OFS_CAPTURE_INPUT_ONE_CNT, 0, 33'h1);
    acc(0, OFS_CAPTURE_INPUT_TWO_POS, 0, {1'b0, p3});
    acc(0, OFS_CAPTURE_INPUT_TWO_CNT, 0, 33'h2);
    acc(0, OFS_CAP_DONE, 0, 33'h3);
    acc(1, OFS_CAPTURE_INPUT_ONE_ACT, 2, 0);
    acc(0, OFS_CAPTURE_INPUT_ONE_CNT, 0, 33'h0);
    acc(0, OFS_CAP_DONE, 0, 33'h2);
    acc(1, OFS_CAPTURE_INPUT_ONE_ACT, 3, 0);
    acc(0, OFS_CAPTURE_INPUT_ONE_ACT, 0, 33'h2);
    acc(1, OFS_CAPTURE_INPUT_TWO_ACT, 0, 0);
    pin(2'b01);
    pin(2'b10);
    acc(0, OFS_CAPTURE_INPUT_TWO_CNT, 0, 33'h2);
    acc(0, OFS_CAPTURE_INPUT_ONE_CNT, 0, 33'h1);
    cyc(3);
    check({1'b0, 32'(expq.size())}, 0);
    stop_test();
  end
endmodule
